//--- verilog/ext_ctrl_pkg.sv
/*
  Constants for the two extended PHY control registers of one port.
  Assumes a 5-bit management register address and 16-bit register data.
*/
// What this block does
// - Register one bit 12 picks SGMII or 1000BASE-X; valid only when global field is 00.
// - Register one bit 11 sets media sense preference, 1 copper, default 0.
// - Register one field 10:8 picks single-media mode; 100 is reserved.
// - Codes 101, 110, 111 enable auto media sense with serdes, 1000BASE-X, 100BASE-FX.
// - Register one field 7:6 overrides media sense: 01 serdes, 10 copper, 11 reserved.
// - Writes to bits 13:8 take effect only on software reset.
// - Bits 13:8 read back the active mode, never the pending one.
// - Register two field 15:13 sets the 100BASE-TX edge rate; sticky.
// - Register two bit 12 enables sticky reduced power mode, reset 0.
// - Register two sticky field 5:4 selects 1.5, 9 or 12 kB packets.
// - Default jumbo lengths assume up to 100 ppm clock offset.
// - Super-sticky bits keep their values through software reset always.
// - Sticky bits survive software reset only while sticky reset enable is set.
package ext_ctrl_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] EXT_CTRL_ONE_ADDR = 5'h17;
  localparam logic [4:0] EXT_CTRL_TWO_ADDR = 5'h18;

  // Register one fields
  localparam int RSVD_RW_HI = 15;
  localparam int RSVD_RW_LO = 14;
  localparam int STAGE_HI = 13;
  localparam int STAGE_LO = 8;
  localparam int MAC_MODE_BIT = 12;
  localparam int PREF_BIT = 11;
  localparam int MEDIA_HI = 10;
  localparam int MEDIA_LO = 8;
  localparam int OVR_HI = 7;
  localparam int OVR_LO = 6;
  localparam int FAR_LB_BIT = 3;

  // Register two fields
  localparam int EDGE_HI = 15;
  localparam int EDGE_LO = 13;
  localparam int LOW_PWR_BIT = 12;
  localparam int JUMBO_HI = 5;
  localparam int JUMBO_LO = 4;
  localparam int CONN_LB_BIT = 0;

  // Reset values
  localparam logic [5:0] STAGE_RST = 6'h00;
  localparam logic [1:0] RSVD_RW_RST = 2'h0;
  localparam logic [1:0] OVR_RST = 2'h0;
  localparam logic FAR_LB_RST = 1'b0;
  localparam logic [2:0] EDGE_RST = 3'h0;
  localparam logic LOW_PWR_RST = 1'b0;
  localparam logic [1:0] JUMBO_RST = 2'h0;
  localparam logic CONN_LB_RST = 1'b0;

  // Codes
  localparam logic [1:0] GLOBAL_MAC_OK = 2'h0;
  localparam logic [2:0] MEDIA_RSVD = 3'h4;
  localparam logic [1:0] OVR_RSVD = 2'h3;
  localparam logic [1:0] JUMBO_NORMAL = 2'h0;
  localparam logic [1:0] JUMBO_9K = 2'h1;
  localparam logic [1:0] JUMBO_12K = 2'h2;

  // Maximum packet lengths in bytes at 100 ppm offset
  localparam logic [13:0] LEN_NORMAL = 14'h0600;
  localparam logic [13:0] LEN_9K = 14'h2400;
  localparam logic [13:0] LEN_12K = 14'h3000;
endpackage : ext_ctrl_pkg

//--- verilog/mode_stage_if.sv
/*
  Carrier between the register bank and the mode staging store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface mode_stage_if;
  logic wr;
  logic [5:0] wdata;
  logic soft_rst;
  logic [5:0] active;
  modport ctrl (output wr, output wdata, output soft_rst, input active);
  modport store (input wr, input wdata, input soft_rst, output active);
endinterface : mode_stage_if
`default_nettype wire

//--- verilog/mode_stage.sv
/*
  Pending and active copies of the super-sticky mode bits 13:8.
  Assumes write and software reset strobes are one-cycle pulses on clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module mode_stage (
  input wire logic clk_in,
  input wire logic rstn_in,
  mode_stage_if.store st
);
  import ext_ctrl_pkg::*;

  logic [5:0] pending_reg;
  logic [5:0] active_reg;

  // Writes land only in the pending copy
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pending_reg <= STAGE_RST;
    end else if (st.wr) begin
      pending_reg <= st.wdata;
    end
  end

  // Adopted on software reset, kept otherwise
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      active_reg <= STAGE_RST;
    end else if (st.soft_rst) begin
      active_reg <= pending_reg;
    end
  end

  assign st.active = active_reg;
endmodule : mode_stage
`default_nettype wire

//--- verilog/ext_phy_ctrl.sv
/*
  Extended PHY control registers one and two of a single port.
  Assumes a management engine supplies address, data and one-cycle read
  and write strobes, plus the software reset pulse, sticky reset enable
  and the global MAC mode field, all on clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_phy_ctrl (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [ext_ctrl_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ext_ctrl_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic soft_reset_in,
  input wire logic sticky_reset_en_in,
  input wire logic [1:0] global_mac_sel_in,
  output logic [ext_ctrl_pkg::DATA_W-1:0] reg_rdata_out,
  output logic mac_1000basex_out,
  output logic mac_sel_valid_out,
  output logic prefer_copper_out,
  output logic [2:0] media_mode_out,
  output logic auto_media_sense_out,
  output logic media_mode_rsvd_out,
  output logic [1:0] auto_media_sense_force_out,
  output logic far_end_loopback_out,
  output logic [2:0] edge_rate_out,
  output logic reduced_power_out,
  output logic [1:0] jumbo_mode_out,
  output logic [13:0] max_pkt_len_out,
  output logic connector_loopback_out
);
  import ext_ctrl_pkg::*;

  mode_stage_if stg ();

  logic [1:0] rsvd_rw_reg;
  logic [1:0] ovr_reg;
  logic far_lb_reg;
  logic [2:0] edge_reg;
  logic low_pwr_reg;
  logic [1:0] jumbo_reg;
  logic conn_lb_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [13:0] max_len_reg;
  logic [13:0] max_len_next;
  logic mac_x_reg;
  logic mac_valid_reg;
  logic pref_reg;
  logic [2:0] media_reg;
  logic ams_reg;
  logic media_rsvd_reg;

  // Address decode
  wire sel_one = (reg_addr_in == EXT_CTRL_ONE_ADDR);
  wire sel_two = (reg_addr_in == EXT_CTRL_TWO_ADDR);
  wire wr_one = reg_wr_in && sel_one;
  wire wr_two = reg_wr_in && sel_two;
  wire sticky_clr = soft_reset_in && !sticky_reset_en_in;
  wire [5:0] active = stg.active;

  assign stg.wr = wr_one;
  assign stg.wdata = reg_wdata_in[STAGE_HI:STAGE_LO];
  assign stg.soft_rst = soft_reset_in;

  mode_stage mode_stage_i (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .st(stg)
  );

  // Readback images; reserved read-only bits are zero
  wire [DATA_W-1:0] img_one = {
    rsvd_rw_reg,
    active,
    ovr_reg,
    2'h0,
    far_lb_reg,
    3'h0
  };
  wire [DATA_W-1:0] img_two = {
    edge_reg,
    low_pwr_reg,
    6'h00,
    jumbo_reg,
    3'h0,
    conn_lb_reg
  };
  wire [DATA_W-1:0] rd_mux = sel_one ? img_one :
                             sel_two ? img_two : {DATA_W{1'b0}};

  // Decoded mode from the active copy
  wire [2:0] media_act = active[MEDIA_HI-STAGE_LO:0];
  wire ams_act = media_act[2] && (media_act != MEDIA_RSVD);

  // Maximum length for the selected jumbo mode
  wire len_9k = (jumbo_reg == JUMBO_9K);
  wire len_12k = (jumbo_reg == JUMBO_12K);
  assign max_len_next = len_9k ? LEN_9K :
                        len_12k ? LEN_12K : LEN_NORMAL;

  // Register one reserved storage, cleared by software reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsvd_rw_reg <= RSVD_RW_RST;
    end else if (soft_reset_in) begin
      rsvd_rw_reg <= RSVD_RW_RST;
    end else if (wr_one) begin
      rsvd_rw_reg <= reg_wdata_in[RSVD_RW_HI:RSVD_RW_LO];
    end
  end

  // Media sense override, cleared by software reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovr_reg <= OVR_RST;
    end else if (soft_reset_in) begin
      ovr_reg <= OVR_RST;
    end else if (wr_one) begin
      ovr_reg <= reg_wdata_in[OVR_HI:OVR_LO];
    end
  end

  // Far-end loopback, cleared by software reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      far_lb_reg <= FAR_LB_RST;
    end else if (soft_reset_in) begin
      far_lb_reg <= FAR_LB_RST;
    end else if (wr_one) begin
      far_lb_reg <= reg_wdata_in[FAR_LB_BIT];
    end
  end

  // Sticky edge rate
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      edge_reg <= EDGE_RST;
    end else if (sticky_clr) begin
      edge_reg <= EDGE_RST;
    end else if (wr_two) begin
      edge_reg <= reg_wdata_in[EDGE_HI:EDGE_LO];
    end
  end

  // Sticky reduced power mode
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_pwr_reg <= LOW_PWR_RST;
    end else if (sticky_clr) begin
      low_pwr_reg <= LOW_PWR_RST;
    end else if (wr_two) begin
      low_pwr_reg <= reg_wdata_in[LOW_PWR_BIT];
    end
  end

  // Sticky jumbo mode
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      jumbo_reg <= JUMBO_RST;
    end else if (sticky_clr) begin
      jumbo_reg <= JUMBO_RST;
    end else if (wr_two) begin
      jumbo_reg <= reg_wdata_in[JUMBO_HI:JUMBO_LO];
    end
  end

  // Register two non-sticky loopback
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conn_lb_reg <= CONN_LB_RST;
    end else if (soft_reset_in) begin
      conn_lb_reg <= CONN_LB_RST;
    end else if (wr_two) begin
      conn_lb_reg <= reg_wdata_in[CONN_LB_BIT];
    end
  end

  // Read data, held until the next read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_reg <= {DATA_W{1'b0}};
    end else if (reg_rd_in) begin
      rdata_reg <= rd_mux;
    end
  end

  // MAC-side selection outputs
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mac_x_reg <= 1'b0;
      mac_valid_reg <= 1'b0;
    end else begin
      mac_x_reg <= active[MAC_MODE_BIT-STAGE_LO];
      mac_valid_reg <= (global_mac_sel_in == GLOBAL_MAC_OK);
    end
  end

  // Media outputs from the active copy
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pref_reg <= 1'b0;
      media_reg <= 3'h0;
      ams_reg <= 1'b0;
      media_rsvd_reg <= 1'b0;
    end else begin
      pref_reg <= active[PREF_BIT-STAGE_LO];
      media_reg <= media_act;
      ams_reg <= ams_act;
      media_rsvd_reg <= (media_act == MEDIA_RSVD);
    end
  end

  // Maximum packet length
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      max_len_reg <= LEN_NORMAL;
    end else begin
      max_len_reg <= max_len_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign mac_1000basex_out = mac_x_reg;
  assign mac_sel_valid_out = mac_valid_reg;
  assign prefer_copper_out = pref_reg;
  assign media_mode_out = media_reg;
  assign auto_media_sense_out = ams_reg;
  assign media_mode_rsvd_out = media_rsvd_reg;
  assign auto_media_sense_force_out = ovr_reg;
  assign far_end_loopback_out = far_lb_reg;
  assign edge_rate_out = edge_reg;
  assign reduced_power_out = low_pwr_reg;
  assign jumbo_mode_out = jumbo_reg;
  assign max_pkt_len_out = max_len_reg;
  assign connector_loopback_out = conn_lb_reg;
endmodule : ext_phy_ctrl
`default_nettype wire

//--- dv/ext_ctrl_props.sv
/* Port assertions for ext_phy_ctrl.
   Assumes a bind to the top module and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module ext_ctrl_props (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic soft_reset_in,
  input wire logic sticky_reset_en_in,
  input wire logic [1:0] global_mac_sel_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic mac_sel_valid_out,
  input wire logic [2:0] media_mode_out,
  input wire logic auto_media_sense_out,
  input wire logic media_mode_rsvd_out,
  input wire logic far_end_loopback_out,
  input wire logic [2:0] edge_rate_out,
  input wire logic [1:0] jumbo_mode_out,
  input wire logic [13:0] max_pkt_len_out,
  input wire logic connector_loopback_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  chk_mac_valid: assert property (1 |=> mac_sel_valid_out == ($past(global_mac_sel_in) == 2'h0))
    else $error("mac select valid wrong");
  chk_media_codes: assert property (auto_media_sense_out == (media_mode_out[2] &&
    media_mode_out != 3'h4) && media_mode_rsvd_out == (media_mode_out == 3'h4))
    else $error("media code flags wrong");
  chk_mode_hold: assert property (!$past(soft_reset_in, 2) |-> $stable(media_mode_out))
    else $error("mode changed without soft reset");
  chk_mode_read: assert property (reg_rd_in && reg_addr_in == 5'h17 && !soft_reset_in
    ##1 !soft_reset_in && !reg_rd_in |=> reg_rdata_out[10:8] == media_mode_out)
    else $error("mode readback not active mode");
  chk_edge_read: assert property (reg_rd_in && reg_addr_in == 5'h18 |=>
    reg_rdata_out[15:13] == $past(edge_rate_out)) else $error("edge rate readback wrong");
  chk_rsvd_zero: assert property (reg_rd_in && reg_addr_in == 5'h18 |=>
    reg_rdata_out[11:6] == 6'h0 && reg_rdata_out[3:1] == 3'h0) else $error("reserved not zero");
  chk_sticky_clr: assert property (soft_reset_in && !sticky_reset_en_in && !reg_wr_in |=>
    edge_rate_out == 3'h0 && jumbo_mode_out == 2'h0) else $error("sticky bits not cleared");
  chk_sticky_keep: assert property (soft_reset_in && sticky_reset_en_in && !reg_wr_in |=>
    $stable(edge_rate_out) && $stable(jumbo_mode_out)) else $error("sticky bits lost");
  chk_loop_clr: assert property (soft_reset_in && !reg_wr_in |=>
    !far_end_loopback_out && !connector_loopback_out) else $error("loopback kept");
  chk_len_jumbo: assert property ($past(jumbo_mode_out) == 2'h1 |->
    max_pkt_len_out == 14'h2400) else $error("9k length wrong");
  chk_len_big: assert property ($past(jumbo_mode_out) == 2'h2 |->
    max_pkt_len_out == 14'h3000) else $error("12k length wrong");
  cover property (soft_reset_in && sticky_reset_en_in);
  cover property (soft_reset_in && !sticky_reset_en_in);
  cover property (auto_media_sense_out);
endmodule : ext_ctrl_props
`default_nettype wire

//--- dv/ext_phy_ctrl_bench.sv
/* Self-checking bench for ext_phy_ctrl.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ext_phy_ctrl_bench;
  import ext_ctrl_pkg::*;
  typedef struct {logic [4:0] a; logic [15:0] d; logic [15:0] e;} row_s;
  row_s rows [3] = '{'{5'h18, 16'hffff, 16'hf031}, '{5'h05, 16'hffff, 16'h0},
    '{5'h17, 16'hd5ff, 16'hc0c8}};
  logic [13:0] lens [4] = '{14'h600, 14'h2400, 14'h3000, 14'h600};
  logic clk_in = 0, rstn_in = 0, reg_wr_in = 0, reg_rd_in = 0, soft_reset_in = 0;
  logic sticky_reset_en_in = 1;
  logic [4:0] reg_addr_in = 5'h0;
  logic [15:0] reg_wdata_in = 16'h0, reg_rdata_out;
  logic [1:0] global_mac_sel_in = 2'h0, auto_media_sense_force_out, jumbo_mode_out;
  logic [2:0] media_mode_out, edge_rate_out;
  logic [13:0] max_pkt_len_out;
  logic mac_1000basex_out, mac_sel_valid_out, prefer_copper_out, auto_media_sense_out;
  logic media_mode_rsvd_out, far_end_loopback_out, reduced_power_out, connector_loopback_out;
  int failures = 0, num_checks = 0, cycles = 0, p = 5;
  ext_phy_ctrl ext_phy_ctrl_i (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .soft_reset_in(soft_reset_in),
    .sticky_reset_en_in(sticky_reset_en_in),
    .global_mac_sel_in(global_mac_sel_in),
    .reg_rdata_out(reg_rdata_out),
    .mac_1000basex_out(mac_1000basex_out),
    .mac_sel_valid_out(mac_sel_valid_out),
    .prefer_copper_out(prefer_copper_out),
    .media_mode_out(media_mode_out),
    .auto_media_sense_out(auto_media_sense_out),
    .media_mode_rsvd_out(media_mode_rsvd_out),
    .auto_media_sense_force_out(auto_media_sense_force_out),
    .far_end_loopback_out(far_end_loopback_out),
    .edge_rate_out(edge_rate_out),
    .reduced_power_out(reduced_power_out),
    .jumbo_mode_out(jumbo_mode_out),
    .max_pkt_len_out(max_pkt_len_out),
    .connector_loopback_out(connector_loopback_out)
  );
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end
  task tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  task chk(string n, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask : chk
  task wr(logic [4:0] a, logic [15:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    tick();
    reg_wr_in = 0;
  endtask : wr
  task rd(logic [4:0] a, logic [15:0] e);
    reg_addr_in = a;
    reg_rd_in = 1;
    tick();
    reg_rd_in = 0;
    chk("rdata", e, reg_rdata_out);
  endtask : rd
  task srst(logic en);
    sticky_reset_en_in = en;
    soft_reset_in = 1;
    tick();
    soft_reset_in = 0;
    repeat (2) tick();
  endtask : srst
  function automatic logic [15:0] enc(int k, logic [1:0] o);
    return {3'h0, k[0], k[1], k[2:0], o, 6'h0};
  endfunction : enc
  task tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) tick();
    rstn_in = 1;
    tick();
    chk("len", 14'h600, max_pkt_len_out);
    rd(5'h17, 16'h0);
    rd(5'h18, 16'h0);
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      rd(rows[r].a, rows[r].e);
    end
    srst(1);
    chk("loop", 5'h05, {far_end_loopback_out, connector_loopback_out, media_mode_out});
    rd(5'h17, 16'h1500);
    for (int i = 0; i < 8; i++) begin
      wr(5'h17, enc(i, i[1:0]));
      wr(5'h18, {10'h0, i[1:0], 4'h0});
      global_mac_sel_in = i[1:0];
      tick();
      chk("force", i[1:0], auto_media_sense_force_out);
      chk("len", lens[i % 4], max_pkt_len_out);
      rd(5'h17, enc(p, i[1:0]));
      srst(1);
      chk("mode", {i[0], i[1], i[2:0], i > 4, i == 4, i[1:0] == 2'h0},
        {mac_1000basex_out, prefer_copper_out, media_mode_out, auto_media_sense_out,
        media_mode_rsvd_out, mac_sel_valid_out});
      p = i;
    end
    wr(5'h18, 16'h9020);
    chk("reg2 outs", 16'h004c, {edge_rate_out, reduced_power_out, jumbo_mode_out,
      connector_loopback_out});
    wr(5'h18, 16'hf031);
    srst(1);
    rd(5'h18, 16'hf030);
    chk("reg2 kept", 16'h007e, {edge_rate_out, reduced_power_out, jumbo_mode_out,
      connector_loopback_out});
    srst(0);
    rd(5'h18, 16'h0);
    chk("reg2 clr", 16'h0000, {edge_rate_out, reduced_power_out, jumbo_mode_out,
      connector_loopback_out});
    chk("len", 14'h600, max_pkt_len_out);
    tally_and_finish();
  end
endmodule : ext_phy_ctrl_bench
bind ext_phy_ctrl ext_ctrl_props ext_ctrl_props_i (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .soft_reset_in(soft_reset_in),
  .sticky_reset_en_in(sticky_reset_en_in),
  .global_mac_sel_in(global_mac_sel_in),
  .reg_rdata_out(reg_rdata_out),
  .mac_sel_valid_out(mac_sel_valid_out),
  .media_mode_out(media_mode_out),
  .auto_media_sense_out(auto_media_sense_out),
  .media_mode_rsvd_out(media_mode_rsvd_out),
  .far_end_loopback_out(far_end_loopback_out),
  .edge_rate_out(edge_rate_out),
  .jumbo_mode_out(jumbo_mode_out),
  .max_pkt_len_out(max_pkt_len_out),
  .connector_loopback_out(connector_loopback_out)
);
`default_nettype wire
